//--- design/crb_builder.sv
// Behaviour
// - Flag bit 0 set when package supports hardware arbitration
// - Flag bit 1 set only when driver status reporting is supported
// - Flag bit 2 shows controller-to-manager flow control support
// - Flag bit 3 shows manager-to-controller flow control support
// - Flag bit 4 shows all-multicast and global multicast command support
// - Flag bits 6:5 give arbitration state; 11b reserved, never sent
// - Broadcast capability word mirrors supported broadcast filter bits
// - Multicast capability word mirrors supported multicast filter bits
// - Buffering word gives inbound buffer bytes; zero means unspecified
// - Event support word uses the event enable bit layout
// - VLAN filter count reported, clamped to at most 15
// - Mixed, multicast and unicast filter counts each reported
// - At least one unicast or mixed filter always reported
// - Unicast plus multicast plus mixed counts never exceed 8
// - VLAN mode bit 0 always reads 1
// - VLAN mode bit 1 shows tagged plus untagged filtering
// - VLAN mode bit 2 shows any-tag plus untagged filtering
// - Channel count field reports supported channels
// - Command 0x17 decoded as the parameter settings request
// - Command 0x16 decoded as the capability query
// - Every capability request without error answered with type 0x96
// - Count word bytes: VLAN, mixed, multicast, unicast from MSB
`default_nettype none
module crb_builder
   import crb_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [3:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [31:0]       reg_rdata,
   input  wire crb_req_t     req,
   input  wire logic         req_err,
   output logic              rsp_valid,
   output logic [7:0]        rsp_type,
   output logic              param_req,
   output crb_report_t       report
);
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [31:0] cfg_reg;
   logic [31:0] bcast_reg;
   logic [31:0] mcast_reg;
   logic [31:0] buf_reg;
   logic [31:0] aen_reg;
   logic [31:0] counts_reg;
   logic [7:0]  chan_reg;
   logic [15:0] cap_cnt_reg;
   logic [15:0] par_cnt_reg;
   logic        rsp_valid_reg;
   logic [7:0]  rsp_type_reg;
   logic        param_req_reg;
   logic [31:0] rdata_reg;
   crb_report_t report_reg;

   wire wr_cfg    = reg_wr && (reg_addr == CRB_A_CFG);
   wire wr_bcast  = reg_wr && (reg_addr == CRB_A_BCAST);
   wire wr_mcast  = reg_wr && (reg_addr == CRB_A_MCAST);
   wire wr_buf    = reg_wr && (reg_addr == CRB_A_BUF);
   wire wr_aen    = reg_wr && (reg_addr == CRB_A_AEN);
   wire wr_counts = reg_wr && (reg_addr == CRB_A_COUNTS);
   wire wr_chan   = reg_wr && (reg_addr == CRB_A_CHAN);

   // ---------------------------------------------------------------
   // Count sanitising
   // ---------------------------------------------------------------
   // Software may write anything; the report is forced legal here
   function automatic logic [31:0] legal_counts(input logic [31:0] c);
      logic [7:0] vl;
      logic [7:0] mx;
      logic [7:0] mc;
      logic [7:0] uc;
      logic [8:0] sum;
      vl = (c[31:24] > CRB_MAX_VLAN) ? CRB_MAX_VLAN : c[31:24];
      mx = c[23:16];
      mc = c[15:8];
      uc = c[7:0];
      if (mx > CRB_MAX_ADDR[7:0]) mx = CRB_MAX_ADDR[7:0];
      if (uc > CRB_MAX_ADDR[7:0]) uc = CRB_MAX_ADDR[7:0];
      if (mc > CRB_MAX_ADDR[7:0]) mc = CRB_MAX_ADDR[7:0];
      if (uc == 8'h00 && mx == 8'h00) uc = 8'h01;
      // Trim multicast first, then mixed, so unicast survives
      sum = {1'b0, uc} + {1'b0, mx} + {1'b0, mc};
      if (sum > CRB_MAX_ADDR) begin
         if ({1'b0, uc} + {1'b0, mx} >= CRB_MAX_ADDR) begin
            mc = 8'h00;
            mx = CRB_MAX_ADDR[7:0] - uc;
         end else begin
            mc = CRB_MAX_ADDR[7:0] - uc - mx;
         end
      end
      return {vl, mx, mc, uc};
   endfunction

   function automatic logic [31:0] legal_flags(input logic [31:0] f);
      logic [31:0] o;
      o = CRB_RST_ZERO;
      o[CRB_FLG_HW_ARB]  = f[CRB_FLG_HW_ARB];
      o[CRB_FLG_DRV_STS] = f[CRB_FLG_DRV_STS];
      o[CRB_FLG_FC_TX]   = f[CRB_FLG_FC_TX];
      o[CRB_FLG_FC_RX]   = f[CRB_FLG_FC_RX];
      o[CRB_FLG_ALL_MC]  = f[CRB_FLG_ALL_MC];
      // Reserved state would confuse the manager; send unknown
      o[CRB_FLG_ARB_LO +: 2] = (f[CRB_FLG_ARB_LO +: 2] == CRB_ARB_RSVD)
                             ? CRB_ARB_UNKNOWN
                             : f[CRB_FLG_ARB_LO +: 2];
      return o;
   endfunction

   wire [31:0] flags_w  = legal_flags(cfg_reg);
   wire [31:0] counts_w = legal_counts(counts_reg);
   // VLAN mode in byte 1, channel count in byte 0; bit 0 pinned high
   wire [7:0]  vmode_w  = {5'h00, cfg_reg[10:9], 1'b1};
   wire [31:0] vlch_w   = {16'h0000, vmode_w, chan_reg};

   wire is_cap   = req.valid && (req.cmd == CRB_CMD_GET_CAP);
   wire is_param = req.valid && (req.cmd == CRB_CMD_GET_PARAM);
   wire cap_ok   = is_cap && !req_err;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_reg    <= CRB_RST_ZERO;
         bcast_reg  <= CRB_RST_ZERO;
         mcast_reg  <= CRB_RST_ZERO;
         buf_reg    <= CRB_RST_ZERO;
         aen_reg    <= CRB_RST_ZERO;
         counts_reg <= CRB_RST_COUNTS;
         chan_reg   <= CRB_RST_CHAN;
      end else begin
         if (wr_cfg)    cfg_reg    <= reg_wdata;  // Bits 10:9 VLAN modes
         if (wr_bcast)  bcast_reg  <= reg_wdata;
         if (wr_mcast)  mcast_reg  <= reg_wdata;
         if (wr_buf)    buf_reg    <= reg_wdata;
         if (wr_aen)    aen_reg    <= reg_wdata;
         if (wr_counts) counts_reg <= reg_wdata;
         if (wr_chan)   chan_reg   <= reg_wdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Response build
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rsp_valid_reg <= 1'b0;
         rsp_type_reg  <= CRB_RSP_NONE;
         param_req_reg <= 1'b0;
         report_reg    <= '0;
      end else begin
         rsp_valid_reg <= cap_ok;
         rsp_type_reg  <= cap_ok ? CRB_RSP_GET_CAP : CRB_RSP_NONE;
         param_req_reg <= is_param && !req_err;
         if (cap_ok) begin
            report_reg.flags     <= flags_w;
            report_reg.bcast     <= bcast_reg;
            report_reg.mcast     <= mcast_reg;
            report_reg.buffering <= buf_reg;
            report_reg.aen       <= aen_reg;
            report_reg.counts    <= counts_w;
            report_reg.vlan_chan <= vlch_w;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cap_cnt_reg <= 16'h0000;
         par_cnt_reg <= 16'h0000;
      end else begin
         if (cap_ok) cap_cnt_reg <= cap_cnt_reg + 16'h0001;
         if (is_param && !req_err) par_cnt_reg <= par_cnt_reg + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Register read
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      if (reg_addr == CRB_A_CFG)         rd_mux = cfg_reg;
      else if (reg_addr == CRB_A_BCAST)  rd_mux = bcast_reg;
      else if (reg_addr == CRB_A_MCAST)  rd_mux = mcast_reg;
      else if (reg_addr == CRB_A_BUF)    rd_mux = buf_reg;
      else if (reg_addr == CRB_A_AEN)    rd_mux = aen_reg;
      else if (reg_addr == CRB_A_COUNTS) rd_mux = counts_w;
      else if (reg_addr == CRB_A_CHAN)   rd_mux = {24'h000000, chan_reg};
      else if (reg_addr == CRB_A_STATUS) rd_mux = {par_cnt_reg, cap_cnt_reg};
      else                               rd_mux = CRB_RST_ZERO;
   end

   always_ff @(posedge mclk) begin
      if (rst) rdata_reg <= CRB_RST_ZERO;
      else if (reg_rd) rdata_reg <= rd_mux;
      else rdata_reg <= CRB_RST_ZERO;
   end

   assign reg_rdata = rdata_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_type  = rsp_type_reg;
   assign param_req = param_req_reg;
   assign report    = report_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Counts that are already legal must pass through untouched
   wire [9:0] raw_sum_w = {2'b00, counts_reg[23:16]}
                        + {2'b00, counts_reg[15:8]}
                        + {2'b00, counts_reg[7:0]};
   wire       raw_uc_ok = (counts_reg[7:0] | counts_reg[23:16]) != 8'h00;
   wire       raw_vl_ok = counts_reg[31:24] <= CRB_MAX_VLAN;
   wire       raw_legal = raw_vl_ok && raw_uc_ok
                        && (raw_sum_w <= {1'b0, CRB_MAX_ADDR});
   // Ten bits so that a broken clamp cannot wrap below the limit
   wire [9:0] rep_sum_w = {2'b00, report.counts[23:16]}
                        + {2'b00, report.counts[15:8]}
                        + {2'b00, report.counts[7:0]};
   wire       param_ok  = is_param && !req_err;

   sequence s_cap_in;
      req.valid && req.cmd == CRB_CMD_GET_CAP && !req_err;
   endsequence
   sequence s_cap_out;
      rsp_valid && rsp_type == CRB_RSP_GET_CAP;
   endsequence
   sequence s_param_in;
      req.valid && req.cmd == CRB_CMD_GET_PARAM && !req_err;
   endsequence
   sequence s_err_in;
      req.valid && req_err;
   endsequence

   chk_cap_answer: assert property (s_cap_in |=> s_cap_out)
      else $error("capability request not answered");
   chk_cap_decode: assert property (rsp_valid |-> $past(is_cap))
      else $error("answer without capability request");
   chk_param_decode: assert property (
      param_req |-> $past(req.cmd) == CRB_CMD_GET_PARAM)
      else $error("parameter pulse for wrong command");
   chk_vlan_limit: assert property (
      s_cap_out |-> report.counts[31:24] <= CRB_MAX_VLAN)
      else $error("VLAN count above limit");
   chk_addr_sum: assert property (
      s_cap_out |-> rep_sum_w <= {1'b0, CRB_MAX_ADDR})
      else $error("filter total above limit");
   chk_unicast_min: assert property (
      s_cap_out |-> (report.counts[7:0] | report.counts[23:16]) != 8'h00)
      else $error("no unicast-capable filter");
   chk_vlan_only: assert property (
      s_cap_out |-> report.vlan_chan[8] && report.vlan_chan[15:11] == 5'h00)
      else $error("VLAN mode bits wrong");
   chk_flag_rsvd: assert property (
      s_cap_out |-> report.flags[31:7] == 25'h0
         && report.flags[6:5] != CRB_ARB_RSVD)
      else $error("reserved flag bits driven");
   chk_flag_copy: assert property (
      s_cap_in |=> report.flags[4:0] == $past(cfg_reg[4:0]))
      else $error("flag bits not copied");
   chk_vmode_copy: assert property (
      s_cap_in |=> report.vlan_chan[10:9] == $past(cfg_reg[10:9]))
      else $error("VLAN mode bits not copied");

   // ---------------------------------------------------------------
   // Flag bits 1 to 6, one by one
   // ---------------------------------------------------------------
   chk_drv_copy: assert property (
      s_cap_in |=> report.flags[1] == $past(cfg_reg[1]))
      else $error("driver status flag not copied");
   chk_fc_tx_copy: assert property (
      s_cap_in |=> report.flags[2] == $past(cfg_reg[2]))
      else $error("outbound flow control flag not copied");
   chk_fc_rx_copy: assert property (
      s_cap_in |=> report.flags[3] == $past(cfg_reg[3]))
      else $error("inbound flow control flag not copied");
   chk_all_mc_copy: assert property (
      s_cap_in |=> report.flags[4] == $past(cfg_reg[4]))
      else $error("all-multicast flag not copied");
   // Reserved arbitration state is folded to unknown, never sent
   chk_arb_state: assert property (
      s_cap_in |=> report.flags[6:5] ==
         (($past(cfg_reg[6:5]) == CRB_ARB_RSVD) ? CRB_ARB_UNKNOWN
         : $past(cfg_reg[6:5])))
      else $error("arbitration state wrong");

   // ---------------------------------------------------------------
   // Payload words
   // ---------------------------------------------------------------
   chk_bcast_copy: assert property (
      s_cap_in |=> report.bcast == $past(bcast_reg))
      else $error("broadcast capability word not copied");
   chk_mcast_copy: assert property (
      s_cap_in |=> report.mcast == $past(mcast_reg))
      else $error("multicast capability word not copied");
   chk_buf_copy: assert property (
      s_cap_in |=> report.buffering == $past(buf_reg))
      else $error("buffering word not copied");
   chk_aen_copy: assert property (
      s_cap_in |=> report.aen == $past(aen_reg))
      else $error("event support word not copied");
   chk_any_vlan: assert property (
      s_cap_in |=> report.vlan_chan[10] == $past(cfg_reg[10]))
      else $error("any-tag VLAN mode bit not copied");
   chk_chan_copy: assert property (
      s_cap_in |=> report.vlan_chan[7:0] == $past(chan_reg))
      else $error("channel count not copied");
   chk_vchan_rsvd: assert property (
      s_cap_out |-> report.vlan_chan[31:16] == 16'h0000)
      else $error("reserved channel word bits driven");

   // ---------------------------------------------------------------
   // Filter counts
   // ---------------------------------------------------------------
   // Clamping must not touch a count that is already within limits
   chk_vlan_keep: assert property (
      s_cap_in ##0 raw_vl_ok
      |=> report.counts[31:24] == $past(counts_reg[31:24]))
      else $error("legal VLAN count altered");
   chk_count_keep: assert property (
      s_cap_in ##0 raw_legal |=> report.counts == $past(counts_reg))
      else $error("legal filter counts altered");
   chk_vlan_rd: assert property (
      reg_rd && reg_addr == CRB_A_COUNTS
      |=> reg_rdata[31:24] <= CRB_MAX_VLAN)
      else $error("VLAN count read above limit");
   chk_sum_rd: assert property (
      reg_rd && reg_addr == CRB_A_COUNTS
      |=> {2'b00, reg_rdata[23:16]} + {2'b00, reg_rdata[15:8]}
          + {2'b00, reg_rdata[7:0]} <= {1'b0, CRB_MAX_ADDR})
      else $error("filter total read above limit");
   chk_uc_rd: assert property (
      reg_rd && reg_addr == CRB_A_COUNTS
      |=> (reg_rdata[7:0] | reg_rdata[23:16]) != 8'h00)
      else $error("count read with no unicast filter");

   // ---------------------------------------------------------------
   // Answer handshake
   // ---------------------------------------------------------------
   chk_type_idle: assert property (
      !rsp_valid |-> rsp_type == CRB_RSP_NONE)
      else $error("response type without answer");
   // Errored packets are dropped before any pulse or count moves
   chk_err_silent: assert property (
      s_err_in |=> !rsp_valid && !param_req)
      else $error("errored request answered");
   chk_param_pulse: assert property (
      s_param_in |=> param_req && !rsp_valid)
      else $error("parameter request not flagged");
   chk_param_alone: assert property (
      param_req |-> $past(param_ok) && !rsp_valid)
      else $error("parameter pulse without request");
   // Report must hold between answers for a late reader
   chk_report_hold: assert property (
      !cap_ok |=> $stable(report))
      else $error("report moved without answer");
   chk_cap_count: assert property (
      cap_ok |=> cap_cnt_reg == $past(cap_cnt_reg) + 16'h0001)
      else $error("capability answer not counted");
   chk_par_count: assert property (
      s_param_in |=> par_cnt_reg == $past(par_cnt_reg) + 16'h0001)
      else $error("parameter request not counted");
   chk_chan_read: assert property (
      reg_rd && reg_addr == CRB_A_CHAN
      |=> reg_rdata == {24'h000000, $past(chan_reg)})
      else $error("channel count read wrong");
endmodule
`default_nettype wire

//--- design/crb_pkg.sv
`default_nettype none
package crb_pkg;
   // ---------------------------------------------------------------
   // Command and response codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CRB_CMD_GET_CAP    = 8'h16;
   localparam logic [7:0] CRB_CMD_GET_PARAM  = 8'h17;
   localparam logic [7:0] CRB_RSP_GET_CAP    = 8'h96;
   localparam logic [7:0] CRB_RSP_NONE       = 8'h00;
   // ---------------------------------------------------------------
   // Capability flag bit positions
   // ---------------------------------------------------------------
   localparam int CRB_FLG_HW_ARB   = 0;
   localparam int CRB_FLG_DRV_STS  = 1;
   localparam int CRB_FLG_FC_TX    = 2;
   localparam int CRB_FLG_FC_RX    = 3;
   localparam int CRB_FLG_ALL_MC   = 4;
   localparam int CRB_FLG_ARB_LO   = 5;
   localparam logic [1:0] CRB_ARB_RSVD = 2'h3;
   localparam logic [1:0] CRB_ARB_UNKNOWN = 2'h0;
   // ---------------------------------------------------------------
   // Limits
   // ---------------------------------------------------------------
   localparam logic [7:0] CRB_MAX_VLAN   = 8'h0f;
   localparam logic [8:0] CRB_MAX_ADDR   = 9'h008;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] CRB_A_CFG      = 4'h0;
   localparam logic [3:0] CRB_A_BCAST    = 4'h1;
   localparam logic [3:0] CRB_A_MCAST    = 4'h2;
   localparam logic [3:0] CRB_A_BUF      = 4'h3;
   localparam logic [3:0] CRB_A_AEN      = 4'h4;
   localparam logic [3:0] CRB_A_COUNTS   = 4'h5;
   localparam logic [3:0] CRB_A_CHAN     = 4'h6;
   localparam logic [3:0] CRB_A_STATUS   = 4'h7;
   localparam logic [31:0] CRB_RST_ZERO  = 32'h0000_0000;
   localparam logic [31:0] CRB_RST_COUNTS = 32'h0000_0001;
   localparam logic [7:0]  CRB_RST_CHAN  = 8'h01;

   typedef struct packed {
      logic        valid;
      logic [7:0]  cmd;
   } crb_req_t;

   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] bcast;
      logic [31:0] mcast;
      logic [31:0] buffering;
      logic [31:0] aen;
      logic [31:0] counts;
      logic [31:0] vlan_chan;
   } crb_report_t;
endpackage
`default_nettype wire

//--- tb/crb_mc_model.sv
`default_nettype none
// ---------------------------------------------------------------
// Manager side: issues command types toward the block
// ---------------------------------------------------------------
module crb_mc_model
   import crb_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       send,
   input  wire logic [7:0] send_cmd,
   input  wire logic       send_err,
   output var crb_req_t    req,
   output var logic        req_err
);
   timeunit 1ns;
   timeprecision 1ps;
   // Header, checksum and pad framed upstream
   always_ff @(posedge mclk) begin
      if (rst) begin
         req <= '0;
         req_err <= 1'b0;
      end else if (send) begin
         req.valid <= 1'b1;
         req.cmd <= send_cmd;
         req_err <= send_err;
      end else begin
         req.valid <= 1'b0;
         // Idle lines never hold a stale type
         req.cmd <= ~req.cmd;
         req_err <= ~req_err;
      end
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench
   import crb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        send = 1'b0;
   logic [7:0]  send_cmd = 8'h00;
   logic        send_err = 1'b0;
   crb_req_t    req;
   logic        req_err;
   logic        rsp_valid;
   logic [7:0]  rsp_type;
   logic        param_req;
   crb_report_t report;
   logic [31:0] m [0:6];
   logic [15:0] cap_n = 16'h0;
   logic [15:0] par_n = 16'h0;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cyc = 0;
   // Awkward count mixes: none, all full, overfull multicast, big vlan
   logic [31:0] corner [0:5] = '{32'h00000000, 32'hff080808,
                                 32'h0f000800, 32'h10080000, 32'h0f040305,
                                 32'h0a020303};

   crb_mc_model mc_u (.mclk(mclk), .rst(rst), .send(send),
      .send_cmd(send_cmd), .send_err(send_err), .req(req), .req_err(req_err));
   crb_builder dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .req(req), .req_err(req_err),
      .rsp_valid(rsp_valid), .rsp_type(rsp_type), .param_req(param_req),
      .report(report));

   always #20 mclk = ~mclk;
   // ---------------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------------
   function automatic logic [31:0] san(input logic [31:0] c);
      logic [7:0] v, x, n, u;
      v = (c[31:24] > 8'h0f) ? 8'h0f : c[31:24];
      x = (c[23:16] > 8'h08) ? 8'h08 : c[23:16];
      n = (c[15:8] > 8'h08) ? 8'h08 : c[15:8];
      u = (c[7:0] > 8'h08) ? 8'h08 : c[7:0];
      if (u == 8'h00 && x == 8'h00) u = 8'h01;
      // Multicast gives way first, then mixed
      if (u + x > 8'h08) begin
         x = 8'h08 - u;
         n = 8'h00;
      end else if (u + x + n > 8'h08) begin
         n = 8'h08 - u - x;
      end
      return {v, x, n, u};
   endfunction
   function automatic logic [31:0] efl();
      logic [1:0] s;
      s = (m[0][6:5] == 2'h3) ? 2'h0 : m[0][6:5];
      return {25'h0, s, m[0][4:0]};
   endfunction
   function automatic logic [31:0] evc();
      return {21'h0, m[0][10:9], 1'b1, m[6][7:0]};
   endfunction
   function automatic logic [31:0] rexp(input int a);
      case (a)
         5: return san(m[5]);
         6: return {24'h0, m[6][7:0]};
         7: return {par_n, cap_n};
         default: return (a < 5) ? m[a] : 32'h0;
      endcase
   endfunction
   // ---------------------------------------------------------------
   // Bus and command tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      if (a < 4'h7) m[a] = d;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e);
   endtask
   task automatic cmd(input logic [7:0] c, input logic e,
                      input logic ans, input logic par);
      @(posedge mclk);
      send <= 1'b1;
      send_cmd <= c;
      send_err <= e;
      @(posedge mclk);
      send <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK(rsp_valid, ans);
      `CHK(rsp_type, ans ? CRB_RSP_GET_CAP : CRB_RSP_NONE);
      `CHK(param_req, par);
      `CHK(report.flags, efl());
      `CHK(report.bcast, m[1]);
      `CHK(report.mcast, m[2]);
      `CHK(report.buffering, m[3]);
      `CHK(report.aen, m[4]);
      `CHK(report.counts, san(m[5]));
      `CHK(report.vlan_chan, evc());
      cap_n = cap_n + 16'(ans);
      par_n = par_n + 16'(par);
   endtask
   task automatic results;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   // Ceiling well above the ~1600 cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      logic [7:0] oc;
      void'($urandom(32'h3fa976c8));
      m = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK(report != '0, 1'b0);
      `CHK(rsp_valid, 1'b0);
      for (int a = 0; a < 16; a++) rd(4'(a), rexp(a));
      for (int it = 0; it < 24; it++) begin
         for (int a = 0; a < 7; a++) wr(4'(a), $urandom());
         if (it < 6) wr(4'h5, corner[it]);
         else wr(4'h5, $urandom() & 32'h1f0f0f0f);
         // Unmapped and read-only places must not move anything
         wr(4'h9, $urandom());
         wr(4'h7, $urandom());
         cmd(CRB_CMD_GET_CAP, 1'b0, 1'b1, 1'b0);
         cmd(CRB_CMD_GET_CAP, 1'b1, 1'b0, 1'b0);
         cmd(CRB_CMD_GET_PARAM, it[0], 1'b0, !it[0]);
         oc = 8'($urandom());
         if (oc == 8'h16 || oc == 8'h17) oc = 8'h00;
         cmd(oc, 1'b0, 1'b0, 1'b0);
         for (int a = 0; a < 16; a++) rd(4'(a), rexp(a));
      end
      // Reset in mid-run must bring every register home
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      m = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
      cap_n = 16'h0;
      par_n = 16'h0;
      @(posedge mclk);
      #1;
      `CHK(report != '0, 1'b0);
      `CHK(rsp_valid, 1'b0);
      for (int a = 0; a < 16; a++) rd(4'(a), rexp(a));
      cmd(CRB_CMD_GET_CAP, 1'b0, 1'b1, 1'b0);
      results();
   end
endmodule
`default_nettype wire
